/* hw/isofrz_top.sv */
`default_nettype none
module isofrz_top
    import isofrz_pkg::*;
#(
    parameter int FAST_CYCLES  = FAST_CYC,
    parameter int SLOW_CYCLES  = SLOW_CYC,
    parameter int GAP_CYCLES   = GAP_CYC,
    parameter int DELAY_CYCLES = DELAY_CYC
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire isofrz_avreq_type av_req,
    output var  isofrz_avrsp_type av_rsp,
    input  wire logic [3:0]       bidir_terminal_in,
    output var  isofrz_bidir_type bidir_terminal,
    input  wire logic             input_terminal_five,
    input  wire logic             isolated_low_voltage_ok,
    input  wire logic             drive_active,
    input  wire logic             drive_reset,
    input  wire logic [5:0]       src_level,
    output logic      [4:0]       input_level,
    output logic      [1:0]       relay_out,
    output logic      [15:0]      relay_one_source,
    output logic      [15:0]      relay_two_source,
    output logic                  freeze_trigger,
    output logic                  drive_trip
);
    localparam logic [CNT_W-1:0] FAST_RELOAD  = CNT_W'(FAST_CYCLES - 1);
    localparam logic [CNT_W-1:0] SLOW_RELOAD  = CNT_W'(SLOW_CYCLES - 1);
    localparam logic [CNT_W-1:0] GAP_RELOAD   = CNT_W'(GAP_CYCLES - 1);
    localparam logic [CNT_W-1:0] DELAY_RELOAD = CNT_W'(DELAY_CYCLES - 1);
    localparam logic [15:0]      FREEZE_CODE  = 16'(SLOT_MENU * 100 + FLAG_IDX);

    function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] cnt,
                                                    input logic [CNT_W-1:0] reload);
        count_down = (cnt == '0) ? reload : cnt - 1'b1;
    endfunction

    function automatic logic [CNT_W-1:0] sat_down(input logic [CNT_W-1:0] cnt);
        sat_down = (cnt == '0) ? cnt : cnt - 1'b1;
    endfunction

    isofrz_ctrl_type  ctrl;
    isofrz_bus_type   bus_state;
    isofrz_scan_type  scan_state;
    logic [5:0]       pin_meta;
    logic [5:0]       pin_sync;
    logic             supply_seen;
    logic [CNT_W-1:0] fast_cnt;
    logic [CNT_W-1:0] slow_cnt;
    logic [CNT_W-1:0] gap_cnt;
    logic [CNT_W-1:0] dly_cnt;
    logic             dly_armed;
    logic             cap_prev;
    logic             capture_flag;
    logic [7:0]       state_word;
    logic [4:0]       route_mask;
    logic             scan_req;
    logic [2:0]       scan_cnt;
    logic [15:0]      mem_rdata;

    // Pins arrive from the isolated side with no relation to core_clk.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {isolated_low_voltage_ok, input_terminal_five, bidir_terminal_in};
            pin_sync <= pin_meta;
        end
    end

    wire       supply_now = pin_sync[5];
    wire       io_off     = ctrl.trip_dis & ~supply_now;
    wire [4:0] pin_level  = {pin_sync[4] ^ ctrl.in5_inv, pin_sync[3:0]};
    wire [4:0] in_active  = io_off ? 5'h00 : pin_level;
    wire       capture_capable_input = in_active[4];

    // Trip: supply lost after it was once seen, or absent while the drive runs.
    wire next_trip = ~ctrl.trip_dis & ~supply_now & (supply_seen | drive_active);

    // Outputs go inactive when the isolated side has no supply and trip_dis is set.
    wire [1:0] next_relay = io_off ? 2'h0
                          : src_level[5:4] ^ {ctrl.rly2_inv, ctrl.rly1_inv};
    wire [3:0] next_out   = io_off ? 4'h0 : src_level[3:0] & ctrl.dir;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            supply_seen        <= 1'b0;
            drive_trip         <= 1'b0;
            relay_out          <= 2'h0;
            bidir_terminal     <= '0;
            input_level        <= 5'h00;
        end else begin
            supply_seen        <= supply_seen | supply_now;
            drive_trip         <= next_trip;
            relay_out          <= next_relay;
            bidir_terminal.out <= next_out;
            bidir_terminal.oe  <= ctrl.dir;
            input_level        <= in_active & {1'b1, ~ctrl.dir};
        end
    end

    // Refresh ticks for the packed state word.
    wire fast_tick = (fast_cnt == '0);
    wire slow_tick = (slow_cnt == '0);

    wire [3:0] io_live   = (ctrl.dir & bidir_terminal.out) | (~ctrl.dir & in_active[3:0]);
    wire [7:0] word_live = {relay_out, supply_now, in_active[4], io_live};
    wire [3:0] io_upd    = (ctrl.dir & {4{slow_tick}}) | (~ctrl.dir & {4{fast_tick}});
    wire [7:0] word_upd  = {{2{slow_tick}}, {2{fast_tick}}, io_upd};
    wire [7:0] next_word = (word_live & word_upd) | (state_word & ~word_upd);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fast_cnt   <= FAST_RELOAD;
            slow_cnt   <= SLOW_RELOAD;
            state_word <= 8'h00;
        end else begin
            fast_cnt   <= count_down(fast_cnt, FAST_RELOAD);
            slow_cnt   <= count_down(slow_cnt, SLOW_RELOAD);
            state_word <= next_word;
        end
    end

    // Avalon-MM decode.
    wire       bus_req   = av_req.read | av_req.write;
    wire       bus_start = (bus_state == BUS_IDLE) & bus_req & ~scan_req
                           & (scan_state == SC_IDLE);
    wire       wr_take   = (bus_state == BUS_ACK) & av_req.write;
    wire       sel_hit   = (av_req.address >= REG_SEL0) & (av_req.address <= REG_SEL6)
                           & (av_req.address[1:0] == 2'h0);
    wire [7:0] sel_off   = av_req.address - REG_SEL0;
    wire [2:0] sel_idx   = sel_off[4:2];
    wire       sw_flag_wr = wr_take & (av_req.address == REG_FLAG);
    wire       ctrl_wr    = wr_take & (av_req.address == REG_CTRL);
    wire       sel_wr     = wr_take & sel_hit;
    wire [2:0] mem_raddr  = (scan_state == SC_RUN) ? scan_cnt : sel_idx;

    isofrz_sel_mem #(
        .DEPTH (SEL_SLOTS),
        .WIDTH (SEL_W)
    ) u_sel_mem (
        .core_clk (core_clk),
        .rst      (rst),
        .we       (sel_wr),
        .waddr    (sel_idx),
        .wdata    (av_req.writedata[15:0]),
        .raddr    (mem_raddr),
        .rdata    (mem_rdata)
    );

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_hit) begin
            rd_mux = {16'h0000, mem_rdata};
        end else begin
            case (av_req.address)
                REG_CTRL:  rd_mux = {24'h000000, ctrl};
                REG_FLAG:  rd_mux = {31'h0000_0000, capture_flag};
                REG_STATE: rd_mux = {24'h000000, state_word};
                REG_STAT:  rd_mux = {29'h0000_0000, freeze_trigger, drive_trip, supply_seen};
                default:   rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Every access takes one fetch cycle so selector reads come from the memory register.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_state <= BUS_IDLE;
            av_rsp    <= '{waitrequest: 1'b1, readdata: 32'h0000_0000};
            ctrl      <= CTRL_RST;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (bus_start) begin
                        bus_state <= BUS_FETCH;
                    end
                end
                BUS_FETCH: begin
                    av_rsp.readdata    <= av_req.read ? rd_mux : 32'h0000_0000;
                    av_rsp.waitrequest <= 1'b0;
                    bus_state          <= BUS_ACK;
                end
                BUS_ACK: begin
                    av_rsp.waitrequest <= 1'b1;
                    bus_state          <= BUS_IDLE;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                end
            endcase
            if (ctrl_wr) begin
                ctrl <= isofrz_ctrl_type'(av_req.writedata[7:0]);
            end
        end
    end

    // Selectors are only acted on at a drive reset: a scan copies them out of memory.
    wire [2:0] scan_prev = scan_cnt - 3'h1;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scan_req         <= 1'b0;
            scan_state       <= SC_IDLE;
            scan_cnt         <= 3'h0;
            route_mask       <= 5'h00;
            relay_one_source <= SEL_RST;
            relay_two_source <= SEL_RST;
        end else begin
            scan_req <= drive_reset | (scan_req & ~((scan_state == SC_IDLE)
                                                   & (bus_state == BUS_IDLE)));
            case (scan_state)
                SC_IDLE: begin
                    scan_cnt <= 3'h0;
                    if (scan_req & (bus_state == BUS_IDLE)) begin
                        scan_state <= SC_RUN;
                    end
                end
                SC_RUN: begin
                    scan_cnt <= scan_cnt + 3'h1;
                    if (scan_cnt != 3'h0) begin
                        if (scan_prev <= 3'(SEL_IN5)) begin
                            route_mask[scan_prev] <= (mem_rdata == FREEZE_CODE);
                        end
                        if (scan_prev == 3'(SEL_RLY1)) begin
                            relay_one_source <= mem_rdata;
                        end
                        if (scan_prev == 3'(SEL_RLY2)) begin
                            relay_two_source <= mem_rdata;
                        end
                    end
                    if (scan_cnt == 3'(NUM_SEL)) begin
                        scan_state <= SC_IDLE;
                    end
                end
                default: begin
                    scan_state <= SC_IDLE;
                end
            endcase
        end
    end

    // Freeze capture.
    wire freeze_routed = route_mask[SEL_IN5];
    wire follow_hit    = |(route_mask[3:0] & ~ctrl.dir);
    wire follow_level  = |(route_mask[3:0] & ~ctrl.dir & in_active[3:0]);
    wire cap_edge      = capture_capable_input & ~cap_prev;
    wire capture_set   = freeze_routed & cap_edge & ~capture_flag
                         & (gap_cnt == '0);
    wire fire          = dly_armed & (dly_cnt == '0);

    // A pin capture wins over a software clear in the same cycle.
    logic next_flag;
    always_comb begin
        next_flag = capture_flag;
        if (capture_set) begin
            next_flag = 1'b1;
        end else if (follow_hit) begin
            next_flag = follow_level;
        end else if (sw_flag_wr) begin
            next_flag = av_req.writedata[0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cap_prev       <= 1'b0;
            capture_flag   <= 1'b0;
            gap_cnt        <= '0;
            dly_cnt        <= '0;
            dly_armed      <= 1'b0;
            freeze_trigger <= 1'b0;
        end else begin
            cap_prev       <= capture_capable_input;
            capture_flag   <= next_flag;
            gap_cnt        <= capture_set ? GAP_RELOAD : sat_down(gap_cnt);
            dly_cnt        <= capture_set ? DELAY_RELOAD : sat_down(dly_cnt);
            dly_armed      <= next_flag & (capture_set | (dly_armed & ~fire));
            freeze_trigger <= next_flag & (freeze_trigger | fire);
        end
    end

    default clocking a_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_freeze_edge;
        cap_edge && freeze_routed && !capture_flag && gap_cnt == '0;
    endsequence

    sequence s_armed;
        capture_flag && dly_armed && dly_cnt == DELAY_RELOAD;
    endsequence

    a_trip_blocked: assert property (ctrl.trip_dis |=> !drive_trip)
        else $error("Trip raised while the supply trip is disabled.");
    a_io_gated: assert property (io_off |=> relay_out == 2'h0
        && bidir_terminal.out == 4'h0 && input_level == 5'h00)
        else $error("I/O active while the isolated supply is absent.");
    a_relay_sense: assert property (!io_off |=> relay_out
        == ($past(src_level[5:4]) ^ $past({ctrl.rly2_inv, ctrl.rly1_inv})))
        else $error("Relay sense does not follow source and invert.");
    a_route_needed: assert property (!freeze_routed && !follow_hit && !sw_flag_wr
        && !capture_flag |=> !capture_flag)
        else $error("Freeze flag set without a route.");
    a_freeze_set: assert property (s_freeze_edge |=> s_armed)
        else $error("Freeze edge did not set the flag.");
    a_event_delay: assert property ($rose(freeze_trigger) |-> $past(dly_armed)
        && $past(dly_cnt) == '0)
        else $error("Freeze event raised at the wrong time.");
    a_flag_sticky: assert property (capture_flag && !follow_hit && !sw_flag_wr
        |=> capture_flag)
        else $error("Freeze flag cleared by itself.");
    a_no_rearm: assert property (capture_flag && !dly_armed |=> !dly_armed)
        else $error("Freeze rearmed while the flag is set.");
    a_follow_data: assert property (follow_hit && !capture_set
        |=> capture_flag == $past(follow_level))
        else $error("Freeze flag does not follow the routed I/O.");
    a_sw_no_event: assert property (sw_flag_wr && !capture_set && !dly_armed
        |=> !dly_armed)
        else $error("Software write produced a freeze event.");
    a_gap_hold: assert property (gap_cnt != '0 && !follow_hit && !sw_flag_wr
        |=> capture_flag == $past(capture_flag))
        else $error("Freeze edge accepted inside the spacing time.");
    a_word_hold: assert property (!fast_tick && !slow_tick |=> $stable(state_word))
        else $error("State word changed between refresh ticks.");
    a_relay_latch: assert property (scan_state == SC_IDLE
        |=> $stable(relay_one_source) && $stable(relay_two_source))
        else $error("Relay source changed outside a drive reset.");
    a_dir_four: assert property (!ctrl.dir[3] |=> !bidir_terminal.oe[3]
        && !bidir_terminal.out[3])
        else $error("Terminal four driven while set as input.");
    a_dir_three: assert property (ctrl.dir[2:0] == 3'h0 |=> bidir_terminal.oe[2:0]
        == 3'h0 && bidir_terminal.out[2:0] == 3'h0)
        else $error("Terminals one to three driven while set as inputs.");
    a_bus_ack: assert property (bus_state == BUS_FETCH |=> !av_rsp.waitrequest
        ##1 av_rsp.waitrequest)
        else $error("Bus answer is not a single cycle.");
endmodule
`default_nettype wire

/* hw/isofrz_pkg.sv */
`default_nettype none
package isofrz_pkg;
    // Timing, held in nanoseconds and derived into core_clk cycles.
    localparam int CLK_HZ     = 100_000_000;
    localparam int NS_PER_CYC = 1_000_000_000 / CLK_HZ;
    localparam int FAST_NS    = 500_000;
    localparam int SLOW_NS    = 4_000_000;
    localparam int GAP_NS     = 500_000;
    localparam int LAT_NS     = 10_000;
    localparam int FAST_CYC   = FAST_NS / NS_PER_CYC;
    localparam int SLOW_CYC   = SLOW_NS / NS_PER_CYC;
    localparam int GAP_CYC    = (GAP_NS + NS_PER_CYC - 1) / NS_PER_CYC;
    localparam int DELAY_CYC  = (FAST_NS + LAT_NS) / NS_PER_CYC;
    localparam int CNT_W      = 20;

    // Register byte offsets on the Avalon-MM slave.
    localparam int          ADDR_W    = 8;
    localparam logic [7:0]  REG_CTRL  = 8'h00;
    localparam logic [7:0]  REG_FLAG  = 8'h04;
    localparam logic [7:0]  REG_STATE = 8'h08;
    localparam logic [7:0]  REG_SEL0  = 8'h0C;
    localparam logic [7:0]  REG_SEL6  = 8'h24;
    localparam logic [7:0]  REG_STAT  = 8'h28;
    localparam logic [7:0]  CTRL_RST  = 8'h00;

    // Route selector slots, a parameter code is menu times 100 plus index.
    localparam int          SEL_W     = 16;
    localparam int          SEL_SLOTS = 8;
    localparam int          NUM_SEL   = 7;
    localparam int          SEL_IN5   = 4;
    localparam int          SEL_RLY1  = 5;
    localparam int          SEL_RLY2  = 6;
    localparam int          SLOT_MENU = 15;
    localparam int          FLAG_IDX  = 19;
    localparam logic [15:0] SEL_RST   = 16'h0000;

    typedef struct packed {
        logic [3:0] dir;
        logic       in5_inv;
        logic       rly2_inv;
        logic       rly1_inv;
        logic       trip_dis;
    } isofrz_ctrl_type;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
    } isofrz_avreq_type;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } isofrz_avrsp_type;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } isofrz_bidir_type;

    typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_ACK} isofrz_bus_type;
    typedef enum logic {SC_IDLE, SC_RUN} isofrz_scan_type;
endpackage
`default_nettype wire

/* hw/isofrz_sel_mem.sv */
`default_nettype none
module isofrz_sel_mem
    import isofrz_pkg::*;
#(
    parameter int DEPTH = SEL_SLOTS,
    parameter int WIDTH = SEL_W
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [WIDTH-1:0]         rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            rdata <= '0;
        end else begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

/* tb/isofrz_field.sv */
`default_nettype none
module isofrz_field
    import isofrz_pkg::*;
(
    input  wire isofrz_bidir_type bidir_terminal,
    input  wire logic [3:0]       field_level,
    input  wire logic             five_level,
    input  wire logic             supply_on,
    output logic      [3:0]       bidir_terminal_in,
    output logic                  input_terminal_five,
    output logic                  isolated_low_voltage_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    // Where the module drives a terminal the field device backs off, so the pin shows the module.
    assign bidir_terminal_in = (bidir_terminal.out & bidir_terminal.oe)
                             | (field_level & ~bidir_terminal.oe);
    // Edge spacing is left to the bench, so one scenario can break it on purpose.
    assign input_terminal_five     = five_level;
    assign isolated_low_voltage_ok = supply_on;
endmodule
`default_nettype wire

/* tb/isolated_io_freeze_and_routing_tb.sv */
`default_nettype none
module isolated_io_freeze_and_routing_tb
    import isofrz_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] FRZ_CODE = 16'h05EF;
    logic             core_clk = 1'b0;
    logic             rst = 1'b1;
    isofrz_avreq_type req = '0;
    isofrz_avrsp_type rsp;
    isofrz_bidir_type bidir;
    logic [3:0]       term_in;
    logic [3:0]       field_lvl = 4'h0;
    logic             in5;
    logic             in5_set = 1'b0;
    logic             sup_ok;
    logic             sup_set = 1'b1;
    logic             drive_active = 1'b0;
    logic             drive_reset = 1'b0;
    logic [5:0]       src_level = 6'h00;
    logic [4:0]       input_level;
    logic [1:0]       relay_out;
    logic [15:0]      r1src;
    logic [15:0]      r2src;
    logic             freeze_trigger;
    logic             drive_trip;
    logic [31:0]      rd;
    int               error_cnt = 0;
    int               samples_checked = 0;

    always #5 core_clk = ~core_clk;

    isofrz_top #(.FAST_CYCLES(8), .SLOW_CYCLES(32), .GAP_CYCLES(20), .DELAY_CYCLES(10)) DUT (
        .core_clk(core_clk), .rst(rst), .av_req(req), .av_rsp(rsp),
        .bidir_terminal_in(term_in), .bidir_terminal(bidir), .input_terminal_five(in5),
        .isolated_low_voltage_ok(sup_ok), .drive_active(drive_active),
        .drive_reset(drive_reset), .src_level(src_level), .input_level(input_level),
        .relay_out(relay_out), .relay_one_source(r1src), .relay_two_source(r2src),
        .freeze_trigger(freeze_trigger), .drive_trip(drive_trip));

    isofrz_field FIELD (
        .bidir_terminal(bidir), .field_level(field_lvl),
        .five_level(in5_set), .supply_on(sup_set), .bidir_terminal_in(term_in),
        .input_terminal_five(in5), .isolated_low_voltage_ok(sup_ok));

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        do begin
            @(posedge core_clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 100);
        rd = rsp.readdata;
        req <= '0;
        if (n >= 100) begin
            error_cnt++;
            close_out();
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Selectors only move at a drive reset scan, so every routing change goes through here.
    task automatic scan();
        @(posedge core_clk);
        drive_reset <= 1'b1;
        @(posedge core_clk);
        drive_reset <= 1'b0;
        repeat (20) @(posedge core_clk);
    endtask

    function automatic logic [7:0] exp_word(input logic [3:0] dir, input logic [3:0] fld,
                                            input logic [5:0] src, input logic p5,
                                            input logic [1:0] inv);
        return {src[5:4] ^ inv, 1'b1, p5, (src[3:0] & dir) | (fld & ~dir)};
    endfunction

    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        close_out();
    end

    initial begin
        logic [3:0]  dir;
        logic [1:0]  inv;
        logic [15:0] code;
        logic        bad;
        int          n;
        void'($urandom(32'h066268C1));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rdchk(REG_CTRL, 32'h0);
        for (int i = 0; i < NUM_SEL; i++) rdchk(REG_SEL0 + 8'(4 * i), 32'h0);
        rdchk(8'h3C, 32'h0);
        code = 16'($urandom_range(2151));
        bus(1'b1, REG_SEL0 + 8'h14, {16'h0, code});
        bus(1'b1, REG_SEL0 + 8'h18, {16'h0, ~code});
        repeat (5) @(posedge core_clk);
        chk({r2src, r1src}, 32'h0);
        scan();
        chk({r2src, r1src}, {~code, code});
        for (int k = 0; k < 4; k++) begin
            inv = 2'(k);
            dir = (k == 0) ? 4'h0 : 4'($urandom);
            bus(1'b1, REG_CTRL, {24'h0, dir, 1'b0, inv, 1'b0});
            src_level <= 6'($urandom);
            field_lvl <= 4'($urandom);
            in5_set <= 1'($urandom);
            repeat (50) @(posedge core_clk);
            chk(relay_out, src_level[5:4] ^ inv);
            chk(bidir.oe, dir);
            chk(bidir.out, src_level[3:0] & dir);
            chk(input_level, {in5_set, field_lvl & ~dir});
            rdchk(REG_STATE, exp_word(dir, field_lvl, src_level, in5_set, inv));
        end
        in5_set <= 1'b0;
        sup_set <= 1'b0;
        drive_active <= 1'b1;
        bus(1'b1, REG_CTRL, 32'hF7);
        repeat (50) @(posedge core_clk);
        chk({drive_trip, input_level, relay_out, bidir.out}, 32'h0);
        bus(1'b1, REG_CTRL, 32'hF6);
        repeat (10) @(posedge core_clk);
        chk(drive_trip, 32'h1);
        rdchk(REG_STAT, 32'h3);
        drive_active <= 1'b0;
        sup_set <= 1'b1;
        bus(1'b1, REG_CTRL, 32'h0);
        bus(1'b1, REG_SEL0 + 8'h10, {16'h0, FRZ_CODE});
        scan();
        bus(1'b1, REG_FLAG, 32'h0);
        @(posedge core_clk);
        in5_set <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (freeze_trigger !== 1'b1 && n < 100);
        chk(n > 10 && n < 20, 32'h1);
        rdchk(REG_FLAG, 32'h1);
        in5_set <= 1'b0;
        repeat (5) @(posedge core_clk);
        rdchk(REG_FLAG, 32'h1);
        chk(freeze_trigger, 32'h1);
        in5_set <= 1'b1;
        repeat (5) @(posedge core_clk);
        bus(1'b1, REG_FLAG, 32'h0);
        repeat (3) @(posedge core_clk);
        chk(freeze_trigger, 32'h0);
        repeat (20) @(posedge core_clk);
        rdchk(REG_FLAG, 32'h0);
        in5_set <= 1'b0;
        repeat (30) @(posedge core_clk);
        in5_set <= 1'b1;
        repeat (4) @(posedge core_clk);
        bus(1'b1, REG_FLAG, 32'h0);
        in5_set <= 1'b0;
        repeat (2) @(posedge core_clk);
        in5_set <= 1'b1;
        repeat (10) @(posedge core_clk);
        rdchk(REG_FLAG, 32'h0);
        repeat (30) @(posedge core_clk);
        bus(1'b1, REG_CTRL, 32'h08);
        repeat (5) @(posedge core_clk);
        in5_set <= 1'b0;
        repeat (10) @(posedge core_clk);
        rdchk(REG_FLAG, 32'h1);
        bus(1'b1, REG_FLAG, 32'h0);
        repeat (30) @(posedge core_clk);
        bus(1'b1, REG_FLAG, 32'h1);
        bad = 1'b0;
        repeat (20) begin
            @(posedge core_clk);
            if (freeze_trigger !== 1'b0) bad = 1'b1;
        end
        chk(bad, 32'h0);
        bus(1'b1, REG_FLAG, 32'h0);
        bus(1'b1, REG_SEL0 + 8'h10, 32'h0);
        scan();
        bus(1'b1, REG_CTRL, 32'h0);
        in5_set <= 1'b1;
        repeat (10) @(posedge core_clk);
        rdchk(REG_FLAG, 32'h0);
        bus(1'b1, REG_SEL0, {16'h0, FRZ_CODE});
        scan();
        field_lvl <= 4'h1;
        repeat (30) @(posedge core_clk);
        rdchk(REG_FLAG, 32'h1);
        chk(freeze_trigger, 32'h0);
        field_lvl <= 4'h0;
        repeat (30) @(posedge core_clk);
        rdchk(REG_FLAG, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
